// ==== pkg/epc_pkg.sv ====
// Package for the EPROM programmer/reader host controller
// Functional notes
// - After supply sag, change address before trusting data
// - Decode select per part, gate shared read strobe
// - Program mode: supply raised, gate high, data driven
// - Program with bounded low pulse on select
// - Pulse then verify, at most 25 pulses
// - Never hold select low steadily while programming
// - Verify: supply raised, select high, gate low
// - Ganged parts share one select pulse
// - ID readout: high voltage line nine, address zero
// - Read both ID bytes to pick algorithm
package epc_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int CLK_MHZ = 250;
   // Times in ns, counts derived at 4 ns per cycle
   localparam int PULSE_NS = 100000;
   localparam int SETUP_NS = 1000;
   localparam int ACCESS_NS = 200;
   localparam int PULSE_CYC = PULSE_NS * CLK_MHZ / 1000;
   localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 16;
   localparam logic [4:0] MAX_PULSES = 5'h19;
   localparam int ID_LINE = 9;
   localparam int LOW_LINE = 0;

   typedef enum logic [1:0] {
      EPC_OP_READ = 2'h0,
      EPC_OP_PROG = 2'h1,
      EPC_OP_ID   = 2'h2
   } epc_op_e;

   typedef enum logic [3:0] {
      EPC_IDLE    = 4'h0,
      EPC_RD_SET  = 4'h1,
      EPC_RD_CAP  = 4'h2,
      EPC_PG_SET  = 4'h3,
      EPC_PG_PUL  = 4'h4,
      EPC_PG_HOLD = 4'h5,
      EPC_VF_SET  = 4'h6,
      EPC_VF_CAP  = 4'h7,
      EPC_DONE    = 4'h8
   } epc_state_e;

   typedef struct packed {
      logic              select_n;
      logic              gate_n;
      logic              supply_hi;
      logic              id_hv;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic              doe;
   } epc_pins_s;

   typedef struct packed {
      epc_state_e        st;
      epc_op_e           op;
      logic [CNT_W-1:0]  cnt;
      logic [4:0]        pulses;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic              ok;
      logic              done;
      epc_pins_s         pins;
   } epc_state_s;
endpackage

// ==== logic/epc_host.sv ====
// Host controller that reads, programs and identifies the EPROM
`timescale 1ns/1ps
module epc_host (
   // Clock and reset
   input  wire logic                      i_clock,
   input  wire logic                      i_nrst,
   // User command
   input  wire logic                      i_start,
   input  wire epc_pkg::epc_op_e          i_op,
   input  wire logic [epc_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [epc_pkg::DATA_W-1:0] i_wdata,
   output logic                           o_ready,
   output logic                           o_done,
   output logic                           o_ok,
   output logic [epc_pkg::DATA_W-1:0]     o_rdata,
   output logic [4:0]                     o_pulses,
   // Device pins
   output epc_pkg::epc_pins_s             o_pins,
   input  wire logic [epc_pkg::DATA_W-1:0] i_data_pins
);
   import epc_pkg::*;

   epc_state_s s_r;
   epc_state_s s_nxt;

   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n - 1);
   endfunction

   // ==========================================================
   // Sequencer
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (s_r.cnt != '0) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
      case (s_r.st)
         EPC_IDLE: begin
            // Idle: deselected, gate high, nothing driven
            s_nxt.pins.select_n = 1'b1;
            s_nxt.pins.gate_n = 1'b1;
            s_nxt.pins.doe = 1'b0;
            if (i_start) begin
               s_nxt.op = i_op;
               s_nxt.wdata = i_wdata;
               s_nxt.pulses = '0;
               s_nxt.ok = 1'b0;
               // Fresh address each access covers supply sags
               s_nxt.pins.addr = i_addr;
               s_nxt.pins.id_hv = 1'b0;
               s_nxt.cnt = cyc(SETUP_CYC);
               if (i_op == EPC_OP_PROG) begin
                  // Raised supply, gate high, data driven
                  s_nxt.pins.supply_hi = 1'b1;
                  s_nxt.pins.dout = i_wdata;
                  s_nxt.pins.doe = 1'b1;
                  s_nxt.st = EPC_PG_SET;
               end else if (i_op == EPC_OP_ID) begin
                  // Lines above zero low, line zero picks the byte, line nine raised
                  // Both id bytes let the user pick the algorithm
                  s_nxt.pins.supply_hi = 1'b0;
                  s_nxt.pins.addr = '0;
                  s_nxt.pins.addr[LOW_LINE] = i_addr[LOW_LINE];
                  s_nxt.pins.id_hv = 1'b1;
                  s_nxt.pins.select_n = 1'b0;
                  s_nxt.st = EPC_RD_SET;
               end else begin
                  s_nxt.pins.supply_hi = 1'b0;
                  s_nxt.pins.select_n = 1'b0;
                  s_nxt.st = EPC_RD_SET;
               end
            end
         end
         EPC_RD_SET: begin
            if (s_r.cnt == '0) begin
               // Gate low after select: data valid later
               s_nxt.pins.gate_n = 1'b0;
               s_nxt.cnt = cyc(ACCESS_CYC);
               s_nxt.st = EPC_RD_CAP;
            end
         end
         EPC_RD_CAP: begin
            if (s_r.cnt == '0) begin
               s_nxt.rdata = i_data_pins;
               s_nxt.ok = 1'b1;
               s_nxt.st = EPC_DONE;
            end
         end
         EPC_PG_SET: begin
            if (s_r.cnt == '0) begin
               // Bounded low pulse on select
               s_nxt.pins.select_n = 1'b0;
               s_nxt.cnt = cyc(PULSE_CYC);
               s_nxt.pulses = s_r.pulses + 5'h01;
               s_nxt.st = EPC_PG_PUL;
            end
         end
         EPC_PG_PUL: begin
            if (s_r.cnt == '0) begin
               s_nxt.pins.select_n = 1'b1;
               s_nxt.cnt = cyc(SETUP_CYC);
               s_nxt.st = EPC_PG_HOLD;
            end
         end
         EPC_PG_HOLD: begin
            if (s_r.cnt == '0) begin
               // Release data before gate falls for verify
               s_nxt.pins.doe = 1'b0;
               s_nxt.cnt = cyc(SETUP_CYC);
               s_nxt.st = EPC_VF_SET;
            end
         end
         EPC_VF_SET: begin
            if (s_r.cnt == '0) begin
               s_nxt.pins.gate_n = 1'b0;
               s_nxt.cnt = cyc(ACCESS_CYC);
               s_nxt.st = EPC_VF_CAP;
            end
         end
         EPC_VF_CAP: begin
            if (s_r.cnt == '0) begin
               s_nxt.rdata = i_data_pins;
               s_nxt.pins.gate_n = 1'b1;
               if (i_data_pins == s_r.wdata) begin
                  s_nxt.ok = 1'b1;
                  s_nxt.st = EPC_DONE;
               end else if (s_r.pulses >= MAX_PULSES) begin
                  // Give up after the pulse limit
                  s_nxt.st = EPC_DONE;
               end else begin
                  // Only zeros program; a one lost can't return
                  s_nxt.pins.dout = s_r.wdata;
                  s_nxt.pins.doe = 1'b1;
                  s_nxt.cnt = cyc(SETUP_CYC);
                  s_nxt.st = EPC_PG_SET;
               end
            end
         end
         EPC_DONE: begin
            s_nxt.pins.select_n = 1'b1;
            s_nxt.pins.gate_n = 1'b1;
            s_nxt.pins.doe = 1'b0;
            s_nxt.pins.supply_hi = 1'b0;
            s_nxt.pins.id_hv = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.st = EPC_IDLE;
         end
         default: begin
            s_nxt.st = EPC_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         s_r <= '0;
         s_r.pins.select_n <= 1'b1;
         s_r.pins.gate_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_ready = (s_r.st == EPC_IDLE);
   assign o_done = s_r.done;
   assign o_ok = s_r.ok;
   assign o_rdata = s_r.rdata;
   assign o_pulses = s_r.pulses;
   assign o_pins = s_r.pins;

   // ==========================================================
   // Checks
   // Cycles select has stood low with the supply raised
   logic [CNT_W-1:0] low_cnt_r;

   always_ff @(posedge i_clock) begin
      if (!i_nrst || s_r.pins.select_n || !s_r.pins.supply_hi) begin
         low_cnt_r <= '0;
      end else begin
         low_cnt_r <= low_cnt_r + 1'b1;
      end
   end

   sequence pulse_start;
      s_r.st == EPC_PG_SET && s_r.cnt == '0;
   endsequence

   sequence pulse_end;
      $rose(o_pins.select_n) && o_pins.supply_hi;
   endsequence

   a_pulse_bounded: assert property (@(posedge i_clock)
      disable iff (!i_nrst) low_cnt_r <= CNT_W'(PULSE_CYC))
      else $error("program pulse not bounded");
   a_pulse_begin: assert property (@(posedge i_clock)
      disable iff (!i_nrst)
      pulse_start |=> !o_pins.select_n && low_cnt_r == '0)
      else $error("program pulse did not start");
   a_pulse_width: assert property (@(posedge i_clock)
      disable iff (!i_nrst)
      pulse_end |-> low_cnt_r == CNT_W'(PULSE_CYC))
      else $error("program pulse width wrong");
   a_pulse_limit: assert property (@(posedge i_clock)
      disable iff (!i_nrst) s_r.pulses <= MAX_PULSES)
      else $error("too many program pulses");
   a_prog_gate_high: assert property (@(posedge i_clock)
      disable iff (!i_nrst)
      !o_pins.select_n && o_pins.supply_hi |-> o_pins.gate_n && o_pins.doe)
      else $error("program pulse without gate high and data");
   a_no_contention: assert property (@(posedge i_clock)
      disable iff (!i_nrst) !o_pins.gate_n |-> !o_pins.doe)
      else $error("host drives data while device may");
   a_verify_mode: assert property (@(posedge i_clock)
      disable iff (!i_nrst)
      s_r.st == EPC_VF_CAP |-> o_pins.select_n && !o_pins.gate_n)
      else $error("verify not in verify mode");
   a_id_lines: assert property (@(posedge i_clock)
      disable iff (!i_nrst)
      o_pins.id_hv |-> o_pins.addr[ADDR_W-1:1] == '0 && !o_pins.supply_hi)
      else $error("id readout lines not low");
   a_read_access: assert property (@(posedge i_clock)
      disable iff (!i_nrst)
      $fell(o_pins.gate_n) && !o_pins.supply_hi |->
      !o_pins.gate_n [*8])
      else $error("read capture too early");
   a_idle_standby: assert property (@(posedge i_clock)
      disable iff (!i_nrst)
      o_ready |-> o_pins.select_n && o_pins.gate_n)
      else $error("idle not in standby");
endmodule

// ==== sim/epc_dev.sv ====
// Behavioural EPROM model facing the host controller
`timescale 1ns/1ps
module epc_dev
   import epc_pkg::*;
#(
   parameter logic [7:0] MAKER_ID = 8'h3c, // Arbitrary value
   parameter logic [7:0] PART_ID  = 8'hc3, // Arbitrary value
   // Gate fall to valid data, in ns
   parameter int         GATE_NS  = 100
) (
   // Device pins
   input  wire epc_pins_s         i_pins,
   // Lose the next program pulse while high
   input  wire logic              i_skip,
   output logic [DATA_W-1:0]      o_data
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic              lost = 1'b0;
   logic              gate_ok = 1'b0;
   logic [DATA_W-1:0] val;
   logic              drv;

   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
   end

   // Cells change only as a select pulse ends in program mode
   always @(posedge i_pins.select_n) begin
      if (i_pins.supply_hi && i_pins.gate_n) begin
         if (i_skip && !lost) begin
            lost = 1'b1;
         end else begin
            mem[i_pins.addr] = mem[i_pins.addr] & i_pins.dout;
            lost = i_skip;
         end
      end
   end

   // Early capture sees a wrong byte until the gate delay ran
   always @(i_pins.gate_n) begin
      gate_ok = 1'b0;
      #GATE_NS gate_ok = !i_pins.gate_n;
   end

   always_comb begin
      drv = !i_pins.gate_n && gate_ok &&
            (i_pins.supply_hi ? i_pins.select_n : !i_pins.select_n);
      val = mem[i_pins.addr];
      if (i_pins.id_hv)
         val = i_pins.addr[LOW_LINE] ? PART_ID : MAKER_ID;
      // Released pins never show a usable stale byte
      o_data = drv ? val : ~val;
   end
endmodule

// ==== sim/epc_host_test.sv ====
// Self-checking testbench of the host controller with the device model
`timescale 1ns/1ps
module epc_host_test;
   import epc_pkg::*;
   logic              i_clock = 1'b0;
   logic              i_nrst = 1'b0;
   logic              i_start = 1'b0;
   epc_op_e           i_op = EPC_OP_READ;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [DATA_W-1:0] i_wdata = '0;
   logic              skip = 1'b0;
   logic              o_ready, o_done, o_ok;
   logic [DATA_W-1:0] o_rdata, dev_data, data_pins, d, d2;
   logic [4:0]        o_pulses;
   epc_pins_s         o_pins;
   logic [14:0]       exp_q [$];
   logic [14:0]       note;
   logic [ADDR_W-1:0] a;
   int                err_count = 0;
   int                compares = 0;
   int                seed = 12;

   always #2 i_clock = ~i_clock;
   assign data_pins = o_pins.doe ? o_pins.dout : dev_data;

   epc_host dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_start(i_start),
      .i_op(i_op), .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready),
      .o_done(o_done), .o_ok(o_ok), .o_rdata(o_rdata),
      .o_pulses(o_pulses), .o_pins(o_pins), .i_data_pins(data_pins));
   epc_dev #(.MAKER_ID(8'h3c), .PART_ID(8'hc3)) dev (.i_pins(o_pins),
      .i_skip(skip), .o_data(dev_data));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Note: {is_program, ok, byte, pulses}
   task automatic cmd(input epc_op_e op, input logic [14:0] ex);
      while (o_ready !== 1'b1) @(negedge i_clock);
      i_op = op;
      i_start = 1'b1;
      exp_q.push_back(ex);
      @(negedge i_clock);
      i_start = 1'b0;
      while (o_ready !== 1'b1) @(negedge i_clock);
      $display("command %0d finished", op);
   endtask

   always @(negedge i_clock) begin
      if (o_done === 1'b1) begin
         note = exp_q.pop_front();
         check({7'h0, o_ok}, {7'h0, note[13]});
         if (note[14])
            check({3'h0, o_pulses}, {3'h0, note[4:0]});
         else
            check(o_rdata, note[12:5]);
      end
   end

   initial begin
      repeat (10) @(negedge i_clock);
      i_nrst = 1'b1;
      check({4'h0, o_ready, o_pins.select_n, o_pins.gate_n, o_pins.doe},
            8'h0e);
      a = 15'($random(seed));
      d = 8'($random(seed)) | 8'h80;
      d2 = d & 8'($random(seed)) & 8'h7f;
      i_addr = a;
      cmd(EPC_OP_READ, {2'b01, 8'hff, 5'h00});
      i_wdata = d;
      cmd(EPC_OP_PROG, {2'b11, 8'h00, 5'h01});
      cmd(EPC_OP_READ, {2'b01, d, 5'h00});
      // First pulse lost: the retry loop must pulse again
      skip = 1'b1;
      i_wdata = d2;
      cmd(EPC_OP_PROG, {2'b11, 8'h00, 5'h02});
      skip = 1'b0;
      cmd(EPC_OP_READ, {2'b01, d2, 5'h00});
      i_addr = a ^ 15'h0001;
      cmd(EPC_OP_READ, {2'b01, 8'hff, 5'h00});
      i_addr = 15'h0000;
      cmd(EPC_OP_ID, {2'b01, 8'h3c, 5'h00});
      i_addr = 15'h0001;
      cmd(EPC_OP_ID, {2'b01, 8'hc3, 5'h00});
      repeat (2) @(negedge i_clock);
      final_report();
   end

   // Tests take about 80k cycles; a hang stops short of 100k
   initial begin
      repeat (95000) @(negedge i_clock);
      err_count++;
      final_report();
   end
endmodule
